// ===== inc/console_pkg.sv
// Shared constants for the operator console control block
package console_pkg;
    localparam int WORD_W = 18;
    localparam int ADDR_W = 15;
    localparam int CHAN_W = 7;
    localparam int NUM_BUTTONS = 12;
    // Button bit positions in the raw button vector
    localparam int BTN_LOAD = 0;
    localparam int BTN_RUN = 1;
    localparam int BTN_STEP = 2;
    localparam int BTN_MRESET = 3;
    localparam int BTN_RST_P = 4;
    localparam int BTN_RST_A = 5;
    localparam int BTN_RST_B = 6;
    localparam int BTN_RST_M = 7;
    localparam int BTN_RST_C = 8;
    localparam int BTN_RST_Y = 9;
    localparam int BTN_SPARE0 = 10;
    localparam int BTN_SPARE1 = 11;
    // Mode selector encodings
    typedef enum logic [2:0] {
        MODE_SET_A = 3'h0,
        MODE_SET_B = 3'h1,
        MODE_SET_C = 3'h2,
        MODE_PROGRAM_RUN = 3'h3,
        MODE_SET_P = 3'h4,
        MODE_DISPLAY_MEM = 3'h5,
        MODE_INSERT_MEM = 3'h6,
        MODE_SPARE = 3'h7
    } mode_e;
    // Buzzer switch encodings
    localparam logic [1:0] BUZZ_UP = 2'h0;
    localparam logic [1:0] BUZZ_CENTER = 2'h1;
    localparam logic [1:0] BUZZ_DOWN = 2'h2;
    // Insert switch three-position encodings
    localparam logic [1:0] INS_CENTER = 2'h0;
    // Reset values
    localparam logic [WORD_W-1:0] WORD_RESET = 18'h00000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 7'h00;
    localparam logic [WORD_W-1:0] ETC_RESET = 18'h00000;
endpackage

// ===== rtl/button_pulse.sv
// Two-flop synchroniser plus one-shot edge detector for one pushbutton
`timescale 1ns/1ps
module button_pulse (
    input wire logic clk,
    input wire logic rst,
    input wire logic btn,
    output logic pulse
);
    logic s1_q, s2_q, s3_q, pulse_q;
    logic s1_d, s2_d, s3_d, pulse_d;

    always_comb begin
        s1_d = btn;
        s2_d = s1_q;
        s3_d = s2_q;
        pulse_d = s2_q & ~s3_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;

    property p_one_shot;
        @(posedge clk) disable iff (rst) pulse |=> !pulse;
    endproperty
    a_one_shot: assert property (p_one_shot)
        else $error("button pulse longer than one cycle");
endmodule

// ===== rtl/console_control.sv
// Operator console control: switches, buttons, lamps and run/halt logic
`timescale 1ns/1ps
module console_control (
    input wire logic clk,
    input wire logic rst,
    input wire logic count_p_off_n,
    input wire logic count_q_off_n,
    input wire logic halt_disable,
    input wire logic program_pos,
    input wire logic [1:0] buzzer_sw,
    input wire logic [2:0] mode_sw,
    input wire logic [35:0] insert_sw,
    input wire logic [11:0] buttons,
    input wire logic word_time,
    input wire logic instr_done,
    input wire logic halt_req,
    input wire logic reader_stopped,
    input wire logic [17:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic buzz_req,
    output logic run,
    output logic step,
    output logic hw_load,
    output logic mem_req,
    output logic mem_we,
    output logic [14:0] mem_addr,
    output logic [17:0] mem_wdata,
    output logic buzzer,
    output logic [17:0] lamp_a,
    output logic [17:0] lamp_b,
    output logic [6:0] lamp_c,
    output logic [14:0] lamp_p,
    output logic [17:0] lamp_m,
    output logic [17:0] lamp_q,
    output logic [6:0] lamp_y,
    output logic lamp_run,
    output logic lamp_mismatch
);
    localparam int W = console_pkg::WORD_W;
    localparam int AW = console_pkg::ADDR_W;
    localparam int CW = console_pkg::CHAN_W;

    // Memory access sequencer for display and insert modes
    typedef enum logic [1:0] {
        MS_IDLE = 2'h0,
        MS_WRITE = 2'h1,
        MS_READ = 2'h2
    } mseq_e;

    logic [console_pkg::NUM_BUTTONS-1:0] bp;
    logic [2:0] msw_s1_q, msw_s2_q;
    logic [35:0] ins_s1_q, ins_s2_q;
    logic [7:0] sw_s1_q, sw_s2_q;
    logic [3:0] in_s1_q, in_s2_q;

    // One synchroniser and one-shot per pushbutton
    genvar gi;
    generate
        for (gi = 0; gi < console_pkg::NUM_BUTTONS; gi++) begin : g_btn
            button_pulse u_btn (
                .clk(clk),
                .rst(rst),
                .btn(buttons[gi]),
                .pulse(bp[gi])
            );
        end
    endgenerate

    // Panel switches come from outside the clock domain
    always_ff @(posedge clk) begin
        if (rst) begin
            msw_s1_q <= 3'h0;
            msw_s2_q <= 3'h0;
            ins_s1_q <= 36'h000000000;
            ins_s2_q <= 36'h000000000;
            sw_s1_q <= 8'h00;
            sw_s2_q <= 8'h00;
            in_s1_q <= 4'h0;
            in_s2_q <= 4'h0;
        end else begin
            msw_s1_q <= mode_sw;
            msw_s2_q <= msw_s1_q;
            ins_s1_q <= insert_sw;
            ins_s2_q <= ins_s1_q;
            sw_s1_q <= {count_p_off_n, count_q_off_n, halt_disable,
                        program_pos, buzzer_sw, 2'h0};
            sw_s2_q <= sw_s1_q;
            in_s1_q <= {halt_req, reader_stopped, buzz_req, 1'b0};
            in_s2_q <= in_s1_q;
        end
    end

    logic cnt_p_inh, cnt_q_inh, hd, prog, halt_s, rdr_stop, buzz_in;
    logic [1:0] bsw;
    console_pkg::mode_e mode;
    logic [W-1:0] ins_val;
    assign cnt_p_inh = sw_s2_q[7];
    assign cnt_q_inh = sw_s2_q[6];
    assign hd = sw_s2_q[5];
    assign prog = sw_s2_q[4];
    assign bsw = sw_s2_q[3:2];
    assign halt_s = in_s2_q[3];
    assign rdr_stop = in_s2_q[2];
    assign buzz_in = in_s2_q[1];
    assign mode = console_pkg::mode_e'(msw_s2_q);

    // Each insert switch is two bits; any non-center position reads as 1
    always_comb begin
        for (int i = 0; i < W; i++) begin
            ins_val[i] = (ins_s2_q[2*i +: 2] != console_pkg::INS_CENTER);
        end
    end

    logic run_q, run_d, load_q, load_d, step_q, step_d;
    logic buzz_q, buzz_d, mis_q, mis_d;
    logic [W-1:0] a_q, a_d, b_q, b_d, m_q, m_d, q_q, q_d;
    logic [CW-1:0] c_q, c_d, y_q, y_d;
    logic [AW-1:0] p_q, p_d;
    mseq_e ms_q, ms_d;
    logic halt_cond, manual_clr, idle;

    assign manual_clr = bp[console_pkg::BTN_MRESET];
    // Halted and no instruction in flight
    assign idle = !run_q && !step_q && ms_q == MS_IDLE;

    always_comb begin
        run_d = run_q;
        load_d = load_q;
        step_d = 1'b0;
        buzz_d = buzz_q;
        mis_d = mis_q;
        a_d = a_q;
        b_d = b_q;
        c_d = c_q;
        p_d = p_q;
        m_d = m_q;
        q_d = q_q;
        y_d = y_q;
        ms_d = ms_q;
        halt_cond = halt_s;
        // Normal instruction and word-time counting
        if (instr_done && (!cnt_p_inh || prog)) begin
            p_d = p_q + 15'h0001;
        end
        if (word_time && (!cnt_q_inh || prog)) begin
            q_d = q_q - 18'h00001;
        end
        if (bp[console_pkg::BTN_RUN]
                && (mode == console_pkg::MODE_PROGRAM_RUN
                || mode == console_pkg::MODE_DISPLAY_MEM
                || mode == console_pkg::MODE_INSERT_MEM)) begin
            run_d = 1'b1;
        end
        if (bp[console_pkg::BTN_LOAD]
                && mode == console_pkg::MODE_PROGRAM_RUN) begin
            load_d = 1'b1;
            run_d = 1'b0;
        end
        if (load_q && rdr_stop) begin
            load_d = 1'b0;
            run_d = 1'b1;
        end
        // Memory sequencer: write then read back, or read only
        unique case (ms_q)
            MS_IDLE: begin
            end
            MS_WRITE: begin
                if (mem_ack) begin
                    ms_d = MS_READ;
                end
            end
            MS_READ: begin
                if (mem_ack) begin
                    ms_d = MS_IDLE;
                    m_d = mem_rdata;
                    if (mem_rdata != ins_val) begin
                        halt_cond = 1'b1;
                        mis_d = 1'b1;
                        if (mode == console_pkg::MODE_INSERT_MEM) begin
                            buzz_d = 1'b1;
                        end
                    end else begin
                        mis_d = 1'b0;
                    end
                    if (mode == console_pkg::MODE_DISPLAY_MEM) begin
                        p_d = p_q + 15'h0001;
                    end
                end
            end
            default: ms_d = MS_IDLE;
        endcase
        if (bp[console_pkg::BTN_STEP]) begin
            if (run_q && !prog) begin
                run_d = 1'b0;
            end else if (idle) begin
                unique case (mode)
                    console_pkg::MODE_SET_A: a_d = ins_val;
                    console_pkg::MODE_SET_B: b_d = ins_val;
                    console_pkg::MODE_SET_C: c_d = ins_val[CW-1:0];
                    console_pkg::MODE_SET_P: p_d = ins_val[AW-1:0];
                    console_pkg::MODE_DISPLAY_MEM: ms_d = MS_READ;
                    console_pkg::MODE_INSERT_MEM: ms_d = MS_WRITE;
                    default: step_d = 1'b1;
                endcase
            end
        end
        if (idle) begin
            if (bp[console_pkg::BTN_RST_P]) p_d = console_pkg::ADDR_RESET;
            if (bp[console_pkg::BTN_RST_A]) a_d = console_pkg::WORD_RESET;
            if (bp[console_pkg::BTN_RST_B]) b_d = console_pkg::WORD_RESET;
            if (bp[console_pkg::BTN_RST_M]) m_d = console_pkg::WORD_RESET;
            if (bp[console_pkg::BTN_RST_C]) c_d = console_pkg::CHAN_RESET;
            if (bp[console_pkg::BTN_RST_Y]) y_d = console_pkg::CHAN_RESET;
        end
        if (halt_cond && !hd && !prog) begin
            run_d = 1'b0;
        end
        if (prog) begin
            run_d = 1'b1;
        end
        // Buzzer: up silences, down blocks, center lets a request sound
        if (bsw == console_pkg::BUZZ_UP || bsw == console_pkg::BUZZ_DOWN) begin
            buzz_d = 1'b0;
        end else if (buzz_in) begin
            buzz_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || manual_clr) begin
            run_q <= 1'b0;
            load_q <= 1'b0;
            step_q <= 1'b0;
            buzz_q <= 1'b0;
            mis_q <= 1'b0;
            a_q <= console_pkg::WORD_RESET;
            b_q <= console_pkg::WORD_RESET;
            m_q <= console_pkg::WORD_RESET;
            q_q <= console_pkg::ETC_RESET;
            c_q <= console_pkg::CHAN_RESET;
            y_q <= console_pkg::CHAN_RESET;
            p_q <= console_pkg::ADDR_RESET;
            ms_q <= MS_IDLE;
        end else begin
            run_q <= run_d;
            load_q <= load_d;
            step_q <= step_d;
            buzz_q <= buzz_d;
            mis_q <= mis_d;
            a_q <= a_d;
            b_q <= b_d;
            m_q <= m_d;
            q_q <= q_d;
            c_q <= c_d;
            y_q <= y_d;
            p_q <= p_d;
            ms_q <= ms_d;
        end
    end

    // Lamps and control outputs from flip-flops; mem_req, mem_we and mem_wdata are decoded from flop state
    assign run = run_q;
    assign step = step_q;
    assign hw_load = load_q;
    assign mem_req = ms_q != MS_IDLE;
    assign mem_we = ms_q == MS_WRITE;
    assign mem_addr = p_q;
    assign mem_wdata = ins_val;
    assign buzzer = buzz_q;
    assign lamp_a = a_q;
    assign lamp_b = b_q;
    assign lamp_c = c_q;
    assign lamp_p = p_q;
    assign lamp_m = m_q;
    assign lamp_q = q_q;
    assign lamp_y = y_q;
    assign lamp_run = run_q;
    assign lamp_mismatch = mis_q;

    property p_prog_run;
        @(posedge clk) disable iff (rst) prog && !manual_clr |=> run_q;
    endproperty
    a_prog_run: assert property (p_prog_run)
        else $error("run not forced in program position");

    property p_q_hold;
        @(posedge clk) disable iff (rst)
            cnt_q_inh && !prog && !manual_clr |=> q_q == $past(q_q);
    endproperty
    a_q_hold: assert property (p_q_hold)
        else $error("elapsed counter moved while inhibited");

    property p_q_dec;
        @(posedge clk) disable iff (rst)
            word_time && !cnt_q_inh && !manual_clr
            |=> q_q == $past(q_q) - 18'h00001;
    endproperty
    a_q_dec: assert property (p_q_dec)
        else $error("elapsed counter did not decrement");

    property p_buzz_quiet;
        @(posedge clk) disable iff (rst)
            bsw != console_pkg::BUZZ_CENTER |=> !buzz_q;
    endproperty
    a_buzz_quiet: assert property (p_buzz_quiet)
        else $error("buzzer sounding outside center position");

    property p_halt;
        @(posedge clk) disable iff (rst)
            halt_s && !hd && !prog |=> !run_q;
    endproperty
    a_halt: assert property (p_halt)
        else $error("halt condition did not stop processor");

    sequence s_insert_mis;
        ms_q == MS_READ && mem_ack && mem_rdata != ins_val
            && mode == console_pkg::MODE_INSERT_MEM;
    endsequence
    property p_insert_mis;
        @(posedge clk) disable iff (rst)
            s_insert_mis and (bsw == console_pkg::BUZZ_CENTER && !manual_clr)
            |=> buzz_q && mis_q;
    endproperty
    a_insert_mis: assert property (p_insert_mis)
        else $error("insert mismatch did not buzz");

    property p_clear;
        @(posedge clk) disable iff (rst)
            manual_clr |=> a_q == 18'h00000 && p_q == 15'h0000 && !run_q;
    endproperty
    a_clear: assert property (p_clear)
        else $error("manual reset did not clear state");

    property p_mem_lamp;
        @(posedge clk) disable iff (rst)
            ms_q == MS_READ && mem_ack && !manual_clr |=> m_q == $past(mem_rdata);
    endproperty
    a_mem_lamp: assert property (p_mem_lamp)
        else $error("displayed word not captured");
endmodule

// ===== verif/mem_model.sv
// Behavioural memory answering the console's memory sequencer
`timescale 1ns/1ps
module mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic corrupt,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [14:0] mem_addr,
    input wire logic [17:0] mem_wdata,
    output logic [17:0] mem_rdata,
    output logic mem_ack
);
    logic [17:0] mem [0:32767];
    logic [1:0] wait_q;
    // Data toggles outside the ack cycle so stale data never passes
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (rst) begin
            wait_q <= 2'h0;
            mem_rdata <= 18'h00000;
        end else if (mem_req && !mem_ack) begin
            if (!slow || wait_q == 2'h3) begin
                wait_q <= 2'h0;
                mem_ack <= 1'b1;
                if (mem_we)
                    mem[mem_addr] <= mem_wdata;
                else
                    mem_rdata <= mem[mem_addr] ^ {17'h00000, corrupt};
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule

// ===== verif/tb_console_control.sv
// Self-checking bench for the operator console control block
`timescale 1ns/1ps
module tb_console_control;
    logic clk, rst, count_p_off_n, count_q_off_n, halt_disable, program_pos;
    logic word_time, instr_done, halt_req, reader_stopped, buzz_req;
    logic mem_ack, slow, corrupt, run, step, hw_load, mem_req, mem_we;
    logic buzzer, lamp_run, lamp_mismatch, e;
    logic [1:0] buzzer_sw;
    logic [2:0] mode_sw;
    logic [35:0] insert_sw;
    logic [11:0] buttons;
    logic [17:0] mem_rdata, mem_wdata, lamp_a, lamp_b, lamp_m, lamp_q;
    logic [17:0] v, w0;
    logic [14:0] mem_addr, lamp_p, p0;
    logic [6:0] lamp_c, lamp_y;
    logic [63:0] r;
    logic [31:0] seed;
    int error_cnt, checked, steps, s0;

    console_control console_control_i (.clk(clk), .rst(rst),
        .count_p_off_n(count_p_off_n), .count_q_off_n(count_q_off_n),
        .halt_disable(halt_disable), .program_pos(program_pos),
        .buzzer_sw(buzzer_sw), .mode_sw(mode_sw), .insert_sw(insert_sw),
        .buttons(buttons), .word_time(word_time), .instr_done(instr_done),
        .halt_req(halt_req), .reader_stopped(reader_stopped),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .buzz_req(buzz_req),
        .run(run), .step(step), .hw_load(hw_load), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .buzzer(buzzer), .lamp_a(lamp_a), .lamp_b(lamp_b), .lamp_c(lamp_c),
        .lamp_p(lamp_p), .lamp_m(lamp_m), .lamp_q(lamp_q), .lamp_y(lamp_y),
        .lamp_run(lamp_run), .lamp_mismatch(lamp_mismatch));

    mem_model mem_model_i (.clk(clk), .rst(rst), .slow(slow),
        .corrupt(corrupt), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
        if (rst)
            steps <= 0;
        else if (step === 1'b1)
            steps <= steps + 1;

    function automatic logic [17:0] dec(input logic [35:0] s);
        for (int i = 0; i < 18; i++)
            dec[i] = |s[2*i +: 2];
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk(18'(got), 18'(exp));
    endtask

    task automatic press(input int b, input int hold);
        buttons[b] = 1'b1;
        tick(hold);
        buttons[b] = 1'b0;
        tick(16);
    endtask

    task automatic strobe(input logic wt);
        word_time = wt;
        instr_done = !wt;
        tick(1);
        word_time = 1'b0;
        instr_done = 1'b0;
        tick(3);
    endtask

    task automatic rnd();
        r = {$random(seed), $random(seed)};
        insert_sw = r[35:0];
        v = dec(insert_sw);
    endtask

    task automatic op(input logic [2:0] m, input int b);
        mode_sw = m;
        press(b, 2);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Whole run is about 630 cycles; allow ample margin
    initial begin
        #(6000 * 50);
        error_cnt++;
        wrap_up();
    end

    initial begin
        seed = 32'h4737;
        {count_p_off_n, count_q_off_n, halt_disable, program_pos} = 4'h0;
        {word_time, instr_done, halt_req, reader_stopped} = 4'h0;
        {buzz_req, slow, corrupt} = 3'h0;
        buzzer_sw = console_pkg::BUZZ_CENTER;
        mode_sw = console_pkg::MODE_PROGRAM_RUN;
        insert_sw = 36'h000000000;
        buttons = 12'h000;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #5 rst = 1'b0;
        tick(2);
        chk1(lamp_run, 1'b0);
        chk(lamp_a, 18'h00000);
        // All switches down must read as ones
        insert_sw = {18{2'h2}};
        op(console_pkg::MODE_SET_A, console_pkg::BTN_STEP);
        chk(lamp_a, 18'h3ffff);
        rnd();
        op(console_pkg::MODE_SET_B, console_pkg::BTN_STEP);
        chk(lamp_b, v);
        rnd();
        op(console_pkg::MODE_SET_C, console_pkg::BTN_STEP);
        chk(18'(lamp_c), 18'(v[6:0]));
        rnd();
        op(console_pkg::MODE_SET_P, console_pkg::BTN_STEP);
        p0 = v[14:0];
        chk(18'(lamp_p), 18'(p0));
        press(console_pkg::BTN_RST_A, 2);
        chk(lamp_a, 18'h00000);
        chk(18'(lamp_p), 18'(p0));
        press(console_pkg::BTN_RST_C, 2);
        chk(18'(lamp_c), 18'h00000);
        $display("test set and reset done");
        rnd();
        w0 = v;
        slow = 1'b1;
        op(console_pkg::MODE_INSERT_MEM, console_pkg::BTN_STEP);
        chk(lamp_m, w0);
        chk1(lamp_mismatch, 1'b0);
        chk(18'(lamp_p), 18'(p0));
        chk1(mem_req, 1'b0);
        rnd();
        slow = 1'b0;
        op(console_pkg::MODE_DISPLAY_MEM, console_pkg::BTN_STEP);
        chk(lamp_m, w0);
        chk1(lamp_mismatch, v !== w0);
        chk(18'(lamp_p), 18'(p0 + 15'h0001));
        op(console_pkg::MODE_INSERT_MEM, console_pkg::BTN_STEP);
        op(console_pkg::MODE_DISPLAY_MEM, console_pkg::BTN_STEP);
        chk(lamp_m, v);
        chk1(lamp_mismatch, 1'b0);
        chk(18'(lamp_p), 18'(p0 + 15'h0002));
        corrupt = 1'b1;
        op(console_pkg::MODE_INSERT_MEM, console_pkg::BTN_STEP);
        chk1(lamp_mismatch, 1'b1);
        chk1(buzzer, 1'b1);
        buzzer_sw = console_pkg::BUZZ_UP;
        tick(4);
        chk1(buzzer, 1'b0);
        buzzer_sw = console_pkg::BUZZ_DOWN;
        press(console_pkg::BTN_STEP, 2);
        chk1(buzzer, 1'b0);
        corrupt = 1'b0;
        press(console_pkg::BTN_RST_M, 2);
        chk(lamp_m, 18'h00000);
        chk(18'(lamp_p), 18'(p0 + 15'h0002));
        press(console_pkg::BTN_RST_P, 2);
        chk(18'(lamp_p), 18'h00000);
        $display("test memory done");
        halt_disable = 1'b1;
        for (int m = 0; m < 8; m++) begin
            op(3'(m), console_pkg::BTN_RUN);
            e = (m == 3 || m == 5 || m == 6);
            chk1(lamp_run, e);
            if (e) begin
                press(console_pkg::BTN_STEP, 2);
                chk1(lamp_run, 1'b0);
            end
        end
        press(console_pkg::BTN_MRESET, 2);
        chk(lamp_b, 18'h00000);
        chk1(buzzer, 1'b0);
        op(console_pkg::MODE_PROGRAM_RUN, console_pkg::BTN_RUN);
        strobe(1'b0);
        chk(18'(lamp_p), 18'h00001);
        strobe(1'b1);
        chk(lamp_q, 18'h3ffff);
        {count_p_off_n, count_q_off_n} = 2'h3;
        tick(4);
        strobe(1'b0);
        strobe(1'b1);
        chk(18'(lamp_p), 18'h00001);
        chk(lamp_q, 18'h3ffff);
        halt_req = 1'b1;
        tick(6);
        chk1(lamp_run, 1'b1);
        halt_disable = 1'b0;
        tick(6);
        chk1(lamp_run, 1'b0);
        halt_req = 1'b0;
        tick(4);
        s0 = steps;
        press(console_pkg::BTN_STEP, 20);
        chk(18'(steps - s0), 18'h00001);
        program_pos = 1'b1;
        halt_req = 1'b1;
        tick(8);
        chk1(run, 1'b1);
        {program_pos, halt_req} = 2'h0;
        press(console_pkg::BTN_MRESET, 2);
        chk1(lamp_run, 1'b0);
        op(console_pkg::MODE_SET_A, console_pkg::BTN_LOAD);
        chk1(hw_load, 1'b0);
        op(console_pkg::MODE_PROGRAM_RUN, console_pkg::BTN_LOAD);
        chk1(hw_load, 1'b1);
        reader_stopped = 1'b1;
        tick(6);
        chk1(hw_load, 1'b0);
        chk1(lamp_run, 1'b1);
        $display("test run control done");
        wrap_up();
    end
endmodule
